/* core/mfc_pkg.sv */
// Constants for the controller-mode frame sync clock configuration
`default_nettype none

package mfc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] MFC_ADDR_ROLE    = 8'h37;
	localparam logic [7:0] MFC_ADDR_PRI_HI  = 8'h38;
	localparam logic [7:0] MFC_ADDR_PRI_LO  = 8'h39;
	localparam logic [7:0] MFC_ADDR_SEC_HI  = 8'h3A;
	localparam logic [7:0] MFC_ADDR_SEC_LO  = 8'h3B;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         MFC_FREQ_LSB     = 5;
	localparam int         MFC_PRI_ROLE_BIT = 4;
	localparam int         MFC_SEC_ROLE_BIT = 3;
	localparam int         MFC_FAMILY_BIT   = 0;
	localparam int         MFC_USE_INT_BIT  = 7;
	localparam int         MFC_INVERT_BIT   = 6;
	localparam logic [7:0] MFC_ROLE_WMASK   = 8'hF9;
	localparam logic [7:0] MFC_ROLE_RESET   = 8'h20;
	localparam logic [7:0] MFC_RATIO_RESET  = 8'h00;
	localparam int         MFC_RATIO_W      = 14;

	// ****************************************************************
	// Clock source code and reference frequencies in kHz
	// ****************************************************************
	localparam logic [2:0] MFC_SRC_FIXED_REF = 3'h4;
	localparam int         MFC_KHZ_W         = 15;
	localparam logic [7:0][MFC_KHZ_W-1:0] MFC_REF_KHZ = {
		15'h6000, 15'h5DC0, 15'h4CE0, 15'h4B00,
		15'h3E80, 15'h32C8, 15'h3000, 15'h2EE0};

	// ****************************************************************
	// Internal bit clock half periods in system clocks, per family
	// ****************************************************************
	localparam int         MFC_DIV_W        = 8;
	localparam logic [7:0] MFC_HALF_48K     = 8'h04;
	localparam logic [7:0] MFC_HALF_44K     = 8'h05;
	localparam int         MFC_SYNC_STAGES  = 3;

endpackage

`default_nettype wire

/* core/mfc_gen_if.sv */
// Link between the configuration core and one frame sync generator
`default_nettype none

interface mfc_gen_if;
	import mfc_pkg::*;
	logic                   enable;
	logic                   clk_level;
	logic                   invert;
	logic [MFC_RATIO_W-1:0] ratio;
	logic                   fsync;
	logic                   frame;

	modport cfg (output enable, output clk_level, output invert,
		output ratio, input fsync, input frame);
	modport gen (input enable, input clk_level, input invert,
		input ratio, output fsync, output frame);
endinterface

`default_nettype wire

/* core/mfc_fsync_gen.sv */
// Frame sync generator counting edges of one selected bit clock
`default_nettype none

module mfc_fsync_gen
	import mfc_pkg::*;
(
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Configuration and result
	mfc_gen_if.gen    gen_port
);

	typedef struct packed {
		logic                   prev;
		logic [MFC_RATIO_W-1:0] count;
		logic                   fsync;
		logic                   frame;
	} mfc_gen_state_t;

	mfc_gen_state_t state;
	mfc_gen_state_t next_state;

	// ****************************************************************
	// Edge counting
	// ****************************************************************
	always_comb
	begin
		logic lvl;
		lvl = gen_port.clk_level ^ gen_port.invert;
		next_state = state;
		next_state.prev = lvl;
		next_state.frame = 1'b0;
		if (!gen_port.enable || gen_port.ratio == '0)
		begin
			next_state.count = '0;
			next_state.fsync = 1'b0;
		end
		else if (lvl && !state.prev)
		begin
			// One frame per ratio edges of the bit clock
			if (state.count >= gen_port.ratio - 14'h0001)
			begin
				next_state.count = '0;
				next_state.fsync = 1'b1;
				next_state.frame = 1'b1;
			end
			else
			begin
				next_state.count = state.count + 14'h0001;
				next_state.fsync = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			state <= '0;
		else
			state <= next_state;
	end

	assign gen_port.fsync = state.fsync;
	assign gen_port.frame = state.frame;

endmodule

`default_nettype wire

/* core/mfc_clock_cfg.sv */
// Controller-mode clock, role and frame sync configuration
// Overview of operation
// - Three-bit reference clock frequency select, reset one
// - Bit four makes primary port controller
// - Bit three makes secondary port controller
// - Bit zero picks 48k or 44.1k family
// - Primary sync uses internal or external bitclock
// - Primary bitclock inversion only for sync generation
// - Primary fourteen-bit ratio across two registers
// - Secondary sync uses internal or external bitclock
// - Secondary bitclock inversion only for sync generation
// - Secondary ratio upper six bits in high register
// - Secondary ratio low byte in next register
// - Source code four selects fixed reference clock when either port is controller
`default_nettype none

module mfc_clock_cfg
	import mfc_pkg::*;
#(
	parameter logic [MFC_DIV_W-1:0] HALF_48K = MFC_HALF_48K,
	parameter logic [MFC_DIV_W-1:0] HALF_44K = MFC_HALF_44K
)
(
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_srst,
	// Register port
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Clock source selection from the neighbouring clock block
	input  wire logic [2:0] i_input_clock_source_select,
	output logic            o_fixed_ref_clock_source,
	output logic      [2:0] o_ref_clock_freq_select,
	output logic [MFC_KHZ_W-1:0] o_ref_clock_khz,
	output logic            o_rate_family_select,
	// Primary port pins
	input  wire logic       i_primary_port_bclk,
	input  wire logic       i_primary_port_fsync,
	output logic            o_primary_port_bclk,
	output logic            o_primary_port_bclk_oe_n,
	output logic            o_primary_port_fsync,
	output logic            o_primary_port_fsync_oe_n,
	output logic            o_primary_port_frame,
	// Secondary port pins
	input  wire logic       i_secondary_port_bclk,
	input  wire logic       i_secondary_port_fsync,
	output logic            o_secondary_port_bclk,
	output logic            o_secondary_port_bclk_oe_n,
	output logic            o_secondary_port_fsync,
	output logic            o_secondary_port_fsync_oe_n,
	output logic            o_secondary_port_frame
);

	typedef struct packed {
		logic [3:0][MFC_SYNC_STAGES-1:0] sync;
		logic [3:0]                      lvl;
		logic [1:0]                      fs_prev;
		logic [7:0]                      role_reg;
		logic [1:0][7:0]                 hi_reg;
		logic [1:0][7:0]                 lo_reg;
		logic [1:0]                      hi_written;
		logic [1:0]                      lo_written;
		logic [1:0][MFC_RATIO_W-1:0]     ratio;
		logic [MFC_DIV_W-1:0]            div;
		logic                            int_bclk;
		logic [7:0]                      rdata;
		logic [1:0]                      bclk_out;
		logic [1:0]                      bclk_oe_n;
		logic [1:0]                      fsync_out;
		logic [1:0]                      fsync_oe_n;
		logic [1:0]                      frame;
		logic                            fixed_ref;
		logic [MFC_KHZ_W-1:0]            ref_khz;
	} mfc_state_t;

	mfc_state_t state;
	mfc_state_t next_state;

	mfc_gen_if pri_link ();
	mfc_gen_if sec_link ();

	logic [3:0] pins;
	logic [1:0] ctrl;
	assign pins = {i_secondary_port_fsync, i_secondary_port_bclk,
		i_primary_port_fsync, i_primary_port_bclk};
	assign ctrl = {state.role_reg[MFC_SEC_ROLE_BIT],
		state.role_reg[MFC_PRI_ROLE_BIT]};

	// ****************************************************************
	// Generator configuration
	// ****************************************************************
	assign pri_link.enable    = ctrl[0];
	assign pri_link.clk_level = state.hi_reg[0][MFC_USE_INT_BIT] ?
		state.int_bclk : state.lvl[0];
	assign pri_link.invert    = state.hi_reg[0][MFC_INVERT_BIT];
	assign pri_link.ratio     = state.ratio[0];
	assign sec_link.enable    = ctrl[1];
	assign sec_link.clk_level = state.hi_reg[1][MFC_USE_INT_BIT] ?
		state.int_bclk : state.lvl[2];
	assign sec_link.invert    = state.hi_reg[1][MFC_INVERT_BIT];
	assign sec_link.ratio     = state.ratio[1];

	mfc_fsync_gen u_pri_gen (
		.i_clock  (i_clock),
		.i_srst   (i_srst),
		.gen_port (pri_link.gen)
	);

	mfc_fsync_gen u_sec_gen (
		.i_clock  (i_clock),
		.i_srst   (i_srst),
		.gen_port (sec_link.gen)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic [MFC_DIV_W-1:0] half;
		logic [1:0]           gen_fs;
		logic [1:0]           gen_frame;
		logic [1:0]           ext_rise;
		half = HALF_48K;
		gen_fs = {sec_link.fsync, pri_link.fsync};
		gen_frame = {sec_link.frame, pri_link.frame};
		ext_rise = '0;
		next_state = state;

		// Pin synchronisers: a change counts once stages two and three agree
		for (int p = 0; p < 4; p++)
		begin
			next_state.sync[p] = {state.sync[p][1:0], pins[p]};
			if (state.sync[p][1] == state.sync[p][2])
				next_state.lvl[p] = state.sync[p][2];
		end
		next_state.fs_prev = {state.lvl[3], state.lvl[1]};
		ext_rise[0] = state.lvl[1] && !state.fs_prev[0];
		ext_rise[1] = state.lvl[3] && !state.fs_prev[1];

		// Internal bit clock, rate chosen by family
		if (state.role_reg[MFC_FAMILY_BIT])
			half = HALF_44K;
		if (state.div >= half - 8'h01)
		begin
			next_state.div = '0;
			next_state.int_bclk = !state.int_bclk;
		end
		else
			next_state.div = state.div + 8'h01;

		// Register writes
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				MFC_ADDR_ROLE:
					next_state.role_reg = i_reg_wdata & MFC_ROLE_WMASK;
				MFC_ADDR_PRI_HI:
				begin
					next_state.hi_reg[0] = i_reg_wdata;
					next_state.hi_written[0] = 1'b1;
				end
				MFC_ADDR_PRI_LO:
				begin
					next_state.lo_reg[0] = i_reg_wdata;
					next_state.lo_written[0] = 1'b1;
				end
				MFC_ADDR_SEC_HI:
				begin
					next_state.hi_reg[1] = i_reg_wdata;
					next_state.hi_written[1] = 1'b1;
				end
				MFC_ADDR_SEC_LO:
				begin
					next_state.lo_reg[1] = i_reg_wdata;
					next_state.lo_written[1] = 1'b1;
				end
				default:
				begin
				end
			endcase
		end

		// Ratio commits once both halves have been written
		for (int q = 0; q < 2; q++)
		begin
			if (next_state.hi_written[q] && next_state.lo_written[q])
			begin
				next_state.ratio[q] = {next_state.hi_reg[q][5:0],
					next_state.lo_reg[q]};
				next_state.hi_written[q] = 1'b0;
				next_state.lo_written[q] = 1'b0;
			end
		end

		// Read data
		unique case (i_reg_addr)
			MFC_ADDR_ROLE:   next_state.rdata = state.role_reg;
			MFC_ADDR_PRI_HI: next_state.rdata = state.hi_reg[0];
			MFC_ADDR_PRI_LO: next_state.rdata = state.lo_reg[0];
			MFC_ADDR_SEC_HI: next_state.rdata = state.hi_reg[1];
			MFC_ADDR_SEC_LO: next_state.rdata = state.lo_reg[1];
			default:         next_state.rdata = 8'h00;
		endcase

		// Pin drive per port role
		for (int q = 0; q < 2; q++)
		begin
			if (ctrl[q])
			begin
				next_state.bclk_oe_n[q] = !state.hi_reg[q][MFC_USE_INT_BIT];
				next_state.bclk_out[q] = state.int_bclk;
				next_state.fsync_oe_n[q] = 1'b0;
				next_state.fsync_out[q] = gen_fs[q];
				next_state.frame[q] = gen_frame[q];
			end
			else
			begin
				next_state.bclk_oe_n[q] = 1'b1;
				next_state.bclk_out[q] = 1'b0;
				next_state.fsync_oe_n[q] = 1'b1;
				next_state.fsync_out[q] = 1'b0;
				next_state.frame[q] = ext_rise[q];
			end
		end

		// Reference clock reporting
		next_state.ref_khz = MFC_REF_KHZ[state.role_reg[7:MFC_FREQ_LSB]];
		next_state.fixed_ref = (i_input_clock_source_select ==
			MFC_SRC_FIXED_REF) && (ctrl != 2'b00);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			state <= '0;
			state.role_reg <= MFC_ROLE_RESET;
			state.hi_reg <= {MFC_RATIO_RESET, MFC_RATIO_RESET};
			state.lo_reg <= {MFC_RATIO_RESET, MFC_RATIO_RESET};
			state.bclk_oe_n <= 2'b11;
			state.fsync_oe_n <= 2'b11;
			state.ref_khz <= MFC_REF_KHZ[1];
		end
		else
			state <= next_state;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_reg_rdata                 = state.rdata;
	assign o_fixed_ref_clock_source    = state.fixed_ref;
	assign o_ref_clock_freq_select     = state.role_reg[7:MFC_FREQ_LSB];
	assign o_ref_clock_khz             = state.ref_khz;
	assign o_rate_family_select        = state.role_reg[MFC_FAMILY_BIT];
	assign o_primary_port_bclk         = state.bclk_out[0];
	assign o_primary_port_bclk_oe_n    = state.bclk_oe_n[0];
	assign o_primary_port_fsync        = state.fsync_out[0];
	assign o_primary_port_fsync_oe_n   = state.fsync_oe_n[0];
	assign o_primary_port_frame        = state.frame[0];
	assign o_secondary_port_bclk       = state.bclk_out[1];
	assign o_secondary_port_bclk_oe_n  = state.bclk_oe_n[1];
	assign o_secondary_port_fsync      = state.fsync_out[1];
	assign o_secondary_port_fsync_oe_n = state.fsync_oe_n[1];
	assign o_secondary_port_frame      = state.frame[1];

endmodule

`default_nettype wire

/* sim/mfc_clock_cfg_checker.sv */
// Port assertions for the frame sync clock configuration block
`default_nettype none

module mfc_clock_cfg_checker
	import mfc_pkg::*;
(
	// Clock, reset and register port
	input wire logic        i_clock,
	input wire logic        i_srst,
	input wire logic        i_reg_wr,
	input wire logic [7:0]  i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic [7:0]  o_reg_rdata,
	// Clock selection
	input wire logic [2:0]  i_input_clock_source_select,
	input wire logic        o_fixed_ref_clock_source,
	input wire logic [2:0]  o_ref_clock_freq_select,
	input wire logic [14:0] o_ref_clock_khz,
	input wire logic        o_rate_family_select,
	// Port pins
	input wire logic        o_primary_port_fsync,
	input wire logic        o_primary_port_fsync_oe_n,
	input wire logic        o_primary_port_frame,
	input wire logic        o_secondary_port_fsync_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	sequence s_role_wr;
		i_reg_wr && i_reg_addr == MFC_ADDR_ROLE;
	endsequence

	freq_write_a: assert property (
		s_role_wr |=> o_ref_clock_freq_select == $past(i_reg_wdata[7:5]))
		else $error("freq select not written");
	family_write_a: assert property (
		s_role_wr |=> o_rate_family_select == $past(i_reg_wdata[0]))
		else $error("rate family not written");
	khz_map_a: assert property (
		$stable(o_ref_clock_freq_select) [*2] |->
		o_ref_clock_khz == MFC_REF_KHZ[o_ref_clock_freq_select])
		else $error("reference kHz wrong");
	rsvd_zero_a: assert property (
		$past(i_reg_addr) == MFC_ADDR_ROLE |-> o_reg_rdata[2:1] == 2'h0)
		else $error("reserved bits read nonzero");
	reset_vals_a: assert property (
		$fell(i_srst) |-> o_ref_clock_freq_select == 3'h1 &&
		o_primary_port_fsync_oe_n && o_secondary_port_fsync_oe_n)
		else $error("reset values wrong");
	fixed_src_a: assert property (
		$stable(i_input_clock_source_select) &&
		$stable(o_primary_port_fsync_oe_n) &&
		$stable(o_secondary_port_fsync_oe_n) |->
		o_fixed_ref_clock_source ==
		(i_input_clock_source_select == MFC_SRC_FIXED_REF &&
		!(o_primary_port_fsync_oe_n && o_secondary_port_fsync_oe_n)))
		else $error("fixed source flag wrong");
	target_quiet_a: assert property (
		o_primary_port_fsync_oe_n [*3] |-> !o_primary_port_fsync)
		else $error("target drives sync");
	frame_sync_a: assert property (
		!o_primary_port_fsync_oe_n && $rose(o_primary_port_fsync) |->
		o_primary_port_frame)
		else $error("no frame at sync rise");
endmodule

bind mfc_clock_cfg mfc_clock_cfg_checker u_checker (
	.i_clock, .i_srst, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
	.i_input_clock_source_select, .o_fixed_ref_clock_source,
	.o_ref_clock_freq_select, .o_ref_clock_khz, .o_rate_family_select,
	.o_primary_port_fsync, .o_primary_port_fsync_oe_n, .o_primary_port_frame,
	.o_secondary_port_fsync_oe_n
);

`default_nettype wire

/* sim/mfc_host_model.sv */
// Host serial port master supplying bit clock and frame sync
`default_nettype none

module mfc_host_model #(
	parameter int RATIO = 8
)
(
	// Control
	input  wire logic i_run,
	// Port pins
	output logic      o_bclk,
	output logic      o_fsync
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt = 0;

	// Offset start keeps the link phase apart from the system clock
	initial
	begin
		o_bclk = 1'h0;
		o_fsync = 1'h0;
		#3;
		forever
		begin
			#32;
			if (!i_run)
			begin
				o_bclk = 1'h0;
				o_fsync = 1'h0;
				cnt = 0;
			end
			else
			begin
				o_bclk = !o_bclk;
				if (!o_bclk)
				begin
					o_fsync = (cnt == 0);
					cnt = (cnt + 1) % RATIO;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* sim/mfc_clock_cfg_tb.sv */
// Self-checking bench for the frame sync clock configuration block
`default_nettype none

module mfc_clock_cfg_tb
	import mfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int P48 = 2 * MFC_HALF_48K;
	localparam int P44 = 2 * MFC_HALF_44K;
	localparam int PEXT = 8;
	localparam int HRAT = 8;

	logic        i_clock = 1'h0;
	logic        i_srst = 1'h1;
	logic        i_reg_wr = 1'h0;
	logic [7:0]  i_reg_addr = 8'h00;
	logic [7:0]  i_reg_wdata = 8'h00;
	logic [7:0]  rdata;
	logic [2:0]  src = 3'h0;
	logic [2:0]  fsel;
	logic [14:0] khz;
	logic        fam, fix, p_bck, p_fs, s_bck, s_fs;
	logic        run_p = 1'h0;
	logic        run_s = 1'h0;
	wire  [3:0]  oe;
	wire  [1:0]  fr;
	wire  [1:0]  bo;
	wire  [1:0]  fo;
	int          err_count = 0;
	int          total_checks = 0;
	logic [14:0] kt [8] = '{15'h2EE0, 15'h3000, 15'h32C8, 15'h3E80,
		15'h4B00, 15'h4CE0, 15'h5DC0, 15'h6000};

	always #4 i_clock = ~i_clock;

	mfc_clock_cfg u_dut (
		.i_clock(i_clock), .i_srst(i_srst), .i_reg_wr(i_reg_wr),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(rdata), .i_input_clock_source_select(src),
		.o_fixed_ref_clock_source(fix), .o_ref_clock_freq_select(fsel),
		.o_ref_clock_khz(khz), .o_rate_family_select(fam),
		.i_primary_port_bclk(p_bck), .i_primary_port_fsync(p_fs),
		.o_primary_port_bclk(bo[0]), .o_primary_port_bclk_oe_n(oe[0]),
		.o_primary_port_fsync(fo[0]), .o_primary_port_fsync_oe_n(oe[1]),
		.o_primary_port_frame(fr[0]),
		.i_secondary_port_bclk(s_bck), .i_secondary_port_fsync(s_fs),
		.o_secondary_port_bclk(bo[1]), .o_secondary_port_bclk_oe_n(oe[2]),
		.o_secondary_port_fsync(fo[1]), .o_secondary_port_fsync_oe_n(oe[3]),
		.o_secondary_port_frame(fr[1])
	);
	mfc_host_model #(.RATIO(HRAT)) u_host_p (.i_run(run_p),
		.o_bclk(p_bck), .o_fsync(p_fs));
	mfc_host_model #(.RATIO(HRAT)) u_host_s (.i_run(run_s),
		.o_bclk(s_bck), .o_fsync(s_fs));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'h1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'h0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_reg_addr <= a;
		@(posedge i_clock);
		#1 chk(16'(rdata), 16'(exp));
	endtask

	task automatic settle();
		repeat (3) @(negedge i_clock);
	endtask

	// High time of a driven bit clock, in system clocks
	task automatic bhigh(input int s, input int exp);
		int n;
		n = 0;
		while (bo[s] !== 1'h0 && n < 100)
		begin
			@(negedge i_clock);
			n++;
		end
		while (bo[s] !== 1'h1 && n < 200)
		begin
			@(negedge i_clock);
			n++;
		end
		n = 0;
		while (bo[s] === 1'h1 && n < 100)
		begin
			@(negedge i_clock);
			n++;
		end
		chk(16'(n), 16'(exp));
	endtask

	// Third frame gap, so a ratio change in flight is never measured
	task automatic gap(input int s, input int exp);
		int n;
		for (int k = 0; k < 3; k++)
		begin
			n = 0;
			do
			begin
				@(negedge i_clock);
				n++;
			end
			while (fr[s] !== 1'h1 && n < 5000);
		end
		chk(16'(n), 16'(exp));
	endtask

	task automatic t_regs();
		rdc(MFC_ADDR_ROLE, 8'h20);
		for (int a = 8'h38; a < 8'h3C; a++) rdc(8'(a), 8'h00);
		chk(16'(khz), 16'h3000);
		wr(MFC_ADDR_ROLE, 8'hF9);
		rdc(MFC_ADDR_ROLE, 8'hF9);
		chk(16'(fam), 16'h1);
		wr(8'h3C, 8'hA5);
		rdc(8'h3C, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			wr(MFC_ADDR_ROLE, {c[2:0], 5'h00});
			settle();
			chk(16'(fsel), 16'(c));
			chk(16'(khz), 16'(kt[c]));
		end
	endtask

	task automatic t_pri();
		wr(MFC_ADDR_ROLE, 8'h10);
		wr(MFC_ADDR_PRI_HI, 8'h80);
		wr(MFC_ADDR_PRI_LO, 8'h04);
		gap(0, 4 * P48);
		chk(16'(oe[1:0]), 16'h0);
		chk(16'(bo[0]), 16'h1);
		chk(16'(fo[0]), 16'h1);
		bhigh(0, MFC_HALF_48K);
		wr(MFC_ADDR_PRI_LO, 8'h06);
		rdc(MFC_ADDR_PRI_LO, 8'h06);
		gap(0, 4 * P48);
		wr(MFC_ADDR_PRI_HI, 8'hC1);
		gap(0, 262 * P48);
		chk(16'(bo[0]), 16'h0);
		wr(MFC_ADDR_ROLE, 8'h11);
		gap(0, 262 * P44);
		bhigh(0, MFC_HALF_44K);
		@(posedge i_clock);
		src <= MFC_SRC_FIXED_REF;
		settle();
		chk(16'(fix), 16'h1);
	endtask

	// Inversion moves the frame by half a bit clock against the pin
	task automatic t_sec();
		logic ph;
		@(posedge i_clock);
		run_s <= 1'h1;
		wr(MFC_ADDR_ROLE, 8'h08);
		wr(MFC_ADDR_SEC_HI, 8'h01);
		wr(MFC_ADDR_SEC_LO, 8'h00);
		gap(1, 256 * PEXT);
		ph = s_bck;
		chk(16'(oe), 16'h7);
		chk(16'(fo[1]), 16'h1);
		wr(MFC_ADDR_SEC_HI, 8'h41);
		wr(MFC_ADDR_SEC_LO, 8'h10);
		gap(1, 272 * PEXT);
		chk(16'(s_bck), 16'(!ph));
		chk(16'(oe), 16'h7);
		wr(MFC_ADDR_SEC_HI, 8'h81);
		bhigh(1, MFC_HALF_48K);
		chk(16'(oe[2]), 16'h0);
		@(posedge i_clock);
		run_s <= 1'h0;
	endtask

	task automatic t_tgt();
		@(posedge i_clock);
		run_p <= 1'h1;
		wr(MFC_ADDR_ROLE, 8'h00);
		wr(MFC_ADDR_PRI_HI, 8'hC0);
		wr(MFC_ADDR_PRI_LO, 8'h04);
		gap(0, HRAT * PEXT);
		chk(16'(oe), 16'hF);
		chk(16'(fo), 16'h0);
		chk(16'(bo), 16'h0);
		chk(16'(fix), 16'h0);
	endtask

	initial
	begin
		repeat (3) @(posedge i_clock);
		i_srst <= 1'h0;
		t_regs();
		t_pri();
		t_sec();
		t_tgt();
		wrap_up();
	end

	initial
	begin
		#600000;
		err_count++;
		wrap_up();
	end
endmodule

`default_nettype wire
